// ==== rtl/afe_serial_target.v ====
/*
 Byte-oriented serial target on a two-wire clock/data bus with start and
 stop conditions. First written byte sets the register pointer, later
 bytes write with auto increment; reads stream from the pointer.
 Assumes the data line is open drain and the host owns the clock.
*/
`timescale 1ns/1ps
`include "afe_status_map.vh"

module afe_serial_target (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // Bus pins
  input wire i_scl,
  input wire i_sda,
  output reg o_sda_oe,
  // Register access
  output reg o_wr_stb,
  output reg [7:0] o_wr_data,
  output reg [7:0] o_ptr,
  input wire [7:0] i_rd_data
);

  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_ADDR = 7'h02;
  localparam [6:0] S_ACK_A = 7'h04;
  localparam [6:0] S_WRITE = 7'h08;
  localparam [6:0] S_ACK_W = 7'h10;
  localparam [6:0] S_READ = 7'h20;
  localparam [6:0] S_RACK = 7'h40;

  reg [1:0] scl_sync;
  reg [1:0] sda_sync;
  reg scl_d;
  reg sda_d;
  reg [6:0] state;
  reg [3:0] bitcnt;
  reg [7:0] shreg;
  reg [7:0] tx;
  reg rw;
  reg have_ptr;
  reg nack;
  wire scl_rise;
  wire scl_fall;
  wire start_cond;
  wire stop_cond;

  // Pins cross into the clock domain through two flops each
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], i_scl};
      sda_sync <= {sda_sync[0], i_sda};
      scl_d <= scl_sync[1];
      sda_d <= sda_sync[1];
    end
  end

  assign scl_rise = scl_sync[1] & ~scl_d;
  assign scl_fall = ~scl_sync[1] & scl_d;
  assign start_cond = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
  assign stop_cond = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];

  // Protocol engine; data changes only while the clock is low
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      state <= S_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'h00;
      rw <= 1'b0;
      have_ptr <= 1'b0;
      nack <= 1'b0;
      o_sda_oe <= 1'b0;
      o_wr_stb <= 1'b0;
      o_wr_data <= 8'h00;
      o_ptr <= 8'h00;
    end else begin
      o_wr_stb <= 1'b0;
      if (start_cond) begin
        state <= S_ADDR;
        bitcnt <= 4'h0;
        o_sda_oe <= 1'b0;
      end else if (stop_cond) begin
        state <= S_IDLE;
        o_sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (state == S_RACK) begin
          nack <= sda_sync[1];
        end else if ((state == S_ADDR || state == S_WRITE ||
                      state == S_READ) && bitcnt != 4'h8) begin // No ack
          shreg <= {shreg[6:0], sda_sync[1]};
          bitcnt <= bitcnt + 4'h1;
        end
      end else if (scl_fall) begin
        case (state)
          S_ADDR: begin
            if (bitcnt == 4'h8) begin
              bitcnt <= 4'h0;
              if (shreg[7:1] == `TARGET_ADDR) begin
                o_sda_oe <= 1'b1;
                rw <= shreg[0];
                have_ptr <= 1'b0;
                state <= S_ACK_A;
              end else begin
                state <= S_IDLE;
              end
            end
          end
          S_ACK_A: begin
            if (rw) begin
              tx <= i_rd_data;
              o_sda_oe <= ~i_rd_data[7];
              state <= S_READ;
            end else begin
              o_sda_oe <= 1'b0;
              state <= S_WRITE;
            end
          end
          S_WRITE: begin
            if (bitcnt == 4'h8) begin
              bitcnt <= 4'h0;
              o_sda_oe <= 1'b1;
              state <= S_ACK_W;
              if (!have_ptr) begin
                o_ptr <= shreg;
                have_ptr <= 1'b1;
              end else begin
                o_wr_stb <= 1'b1;
                o_wr_data <= shreg;
              end
            end
          end
          S_ACK_W: begin
            o_sda_oe <= 1'b0;
            state <= S_WRITE;
          end
          S_READ: begin
            if (bitcnt == 4'h8) begin
              bitcnt <= 4'h0;
              o_sda_oe <= 1'b0;
              o_ptr <= o_ptr + 8'h01;
              state <= S_RACK;
            end else begin
              o_sda_oe <= ~tx[6];
              tx <= {tx[6:0], 1'b0};
            end
          end
          S_RACK: begin
            if (nack) begin
              state <= S_IDLE;
            end else begin
              tx <= i_rd_data;
              o_sda_oe <= ~i_rd_data[7];
              state <= S_READ;
            end
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
      end else if (o_wr_stb) begin
        // Advance after each stored data byte
        o_ptr <= o_ptr + 8'h01;
      end
    end
  end

endmodule

// ==== rtl/afe_status_fet_control.v ====
/*
 Status, alert and drive control block of a battery monitor front end.
 Holds the write-one-to-clear status register, drive controls, load
 detection, alert sampling and clamped conversion results behind the
 serial target port. Assumes analog comparators and converters feed it;
 comparator levels are asynchronous, conversion codes share this clock.
*/
`timescale 1ns/1ps
`include "afe_status_map.vh"

// Function
// - A status bit clears only when the host writes one to it.
// - Writing all ones clears every flag whose cause has gone and all zeros clears none.
// - Clearing a fault flag never turns a drive output back on.
// - A drive output is on only if commanded and no fault is latched.
// - The alert pin is sampled near 256 kHz with no filtering.
// - A high alert sample drives the alert pin high three ticks later.
// - The target answers at seven-bit address 0x08.
// - Ready-fault sets on a low group supply and holds until recovered.
// - Temperature results follow a source change within two seconds.
// - Load-present tracks the charge pin only with both drives off.
// - Results are 14-bit codes clamped to a ceiling of 0x3DE1.
// - Drive outputs are actively driven low when off.

module afe_status_fet_control #(
  parameter [27:0] TEMP_UPDATE_CYCLES = `TEMP_UPDATE_CYCLES
) (
  // Clock and reset
  input wire I_SYS_CLK,
  input wire I_RST_B,
  // Serial target pins
  input wire I_SCL,
  input wire I_SDA,
  output reg O_SDA_OUT,
  output wire O_SDA_OE,
  // Alert pin
  input wire I_ALERT,
  output reg O_ALERT_OUT,
  output reg O_ALERT_OE,
  // Analog comparator levels
  input wire [3:0] I_FAULT_CMP,
  input wire I_GROUP_SUPPLY_LOW,
  input wire I_LOAD_CMP,
  // Conversion codes
  input wire [13:0] I_VOLT_CODE,
  input wire [13:0] I_TEMP_INT_CODE,
  input wire [13:0] I_TEMP_EXT_CODE,
  // Drive pins
  output reg O_CHARGE_DRIVE_PIN,
  output reg O_DISCHARGE_DRIVE_PIN
);

  reg [7:0] system_status;
  reg [7:0] next_status;
  reg charge_drive_control;
  reg discharge_drive_control;
  reg temp_sel;
  reg load_present;
  reg [13:0] volt_result;
  reg [13:0] temp_result;
  reg [27:0] temp_cnt;
  reg [8:0] div_cnt;
  reg sample_tick;
  reg [`ALERT_DELAY_TICKS-1:0] alert_pipe;
  reg [1:0] alert_sync;
  reg [5:0] cmp_meta;
  reg [5:0] cmp_sync;
  reg [7:0] rd_data;
  wire [7:0] ptr;
  wire [7:0] wr_data;
  wire wr_stb;
  wire [3:0] fault_lvl;
  wire supply_low;
  wire load_lvl;
  wire fault_latched;
  wire status_wr;

  // Clamp a raw code to the reportable ceiling
  function [13:0] clamp_code;
    input [13:0] code;
    begin
      if (code > `ADC_MAX_CODE) begin
        clamp_code = `ADC_MAX_CODE;
      end else begin
        clamp_code = code;
      end
    end
  endfunction

  afe_serial_target u_target (
    .i_clk(I_SYS_CLK),
    .i_rst_b(I_RST_B),
    .i_scl(I_SCL),
    .i_sda(I_SDA),
    .o_sda_oe(O_SDA_OE),
    .o_wr_stb(wr_stb),
    .o_wr_data(wr_data),
    .o_ptr(ptr),
    .i_rd_data(rd_data)
  );

  // Comparator and alert pins pass two flops before any logic
  always @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      cmp_meta <= 6'h00;
      cmp_sync <= 6'h00;
      alert_sync <= 2'h0;
    end else begin
      cmp_meta <= {I_LOAD_CMP, I_GROUP_SUPPLY_LOW, I_FAULT_CMP};
      cmp_sync <= cmp_meta;
      alert_sync <= {alert_sync[0], I_ALERT};
    end
  end

  assign fault_lvl = cmp_sync[3:0];
  assign supply_low = cmp_sync[4];
  assign load_lvl = cmp_sync[5];
  assign fault_latched = |(system_status & `STATUS_FAULT_MASK);
  assign status_wr = wr_stb && (ptr == `REG_SYSTEM_STATUS);

  // Alert sample divider; one enable pulse per sample period
  always @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      div_cnt <= 9'h000;
      sample_tick <= 1'b0;
    end else if (div_cnt == `ALERT_DIV_LAST) begin
      div_cnt <= 9'h000;
      sample_tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 9'h001;
      sample_tick <= 1'b0;
    end
  end

  // Status next value: sets beat a same-cycle clear
  always @* begin
    next_status = system_status;
    if (status_wr) begin
      next_status = system_status & ~wr_data;
    end
    next_status[`ST_OCD] = next_status[`ST_OCD] | fault_lvl[0];
    next_status[`ST_SCD] = next_status[`ST_SCD] | fault_lvl[1];
    next_status[`ST_OV] = next_status[`ST_OV] | fault_lvl[2];
    next_status[`ST_UV] = next_status[`ST_UV] | fault_lvl[3];
    // Single high sample counts; no noise filter by design
    if (sample_tick && alert_sync[1]) begin
      next_status[`ST_EXT_ALERT] = 1'b1;
    end
    // Held while any group supply is still low, so clear waits
    if (supply_low) begin
      next_status[`ST_READY_FAULT] = 1'b1;
    end
    next_status = next_status & `STATUS_USED_MASK;
  end

  always @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      system_status <= `STATUS_RESET;
    end else begin
      system_status <= next_status;
    end
  end

  // Drive control bits; a new fault drops them so a clear cannot
  // bring the drives back without a fresh host command
  always @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      charge_drive_control <= 1'b0;
      discharge_drive_control <= 1'b0;
      temp_sel <= 1'b0;
    end else begin
      if (wr_stb && ptr == `REG_DRIVE_CTRL) begin
        charge_drive_control <= wr_data[`CTL_CHARGE];
        discharge_drive_control <= wr_data[`CTL_DISCHARGE];
        temp_sel <= wr_data[`CTL_TEMP_SEL];
      end
      if (|(next_status & `STATUS_FAULT_MASK)) begin
        charge_drive_control <= 1'b0;
        discharge_drive_control <= 1'b0;
      end
    end
  end

  // Drive pins are hard driven both ways, low pulls down actively
  always @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      O_CHARGE_DRIVE_PIN <= 1'b0;
      O_DISCHARGE_DRIVE_PIN <= 1'b0;
    end else begin
      O_CHARGE_DRIVE_PIN <= charge_drive_control & ~fault_latched;
      O_DISCHARGE_DRIVE_PIN <= discharge_drive_control & ~fault_latched;
    end
  end

  // Load detect is meaningless with either drive on
  always @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      load_present <= 1'b0;
    end else if (charge_drive_control || discharge_drive_control) begin
      load_present <= 1'b0;
    end else begin
      load_present <= load_lvl;
    end
  end

  // Alert drive: request flows through three sample-period stages
  always @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      alert_pipe <= {`ALERT_DELAY_TICKS{1'b0}};
      O_ALERT_OUT <= 1'b0;
      O_ALERT_OE <= 1'b0;
    end else begin
      if (sample_tick) begin
        alert_pipe <= {alert_pipe[`ALERT_DELAY_TICKS-2:0],
                       |system_status};
      end
      O_ALERT_OUT <= 1'b1;
      O_ALERT_OE <= alert_pipe[`ALERT_DELAY_TICKS-1];
    end
  end

  // Results: voltage tracks each cycle, temperature only on the slow
  // update period, which bounds source-switch latency
  always @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      volt_result <= 14'h0000;
      temp_result <= 14'h0000;
      temp_cnt <= 28'h0000000;
    end else begin
      volt_result <= clamp_code(I_VOLT_CODE);
      if (temp_cnt >= TEMP_UPDATE_CYCLES - 28'h0000001) begin
        temp_cnt <= 28'h0000000;
        temp_result <= clamp_code(temp_sel ? I_TEMP_EXT_CODE
                                           : I_TEMP_INT_CODE);
      end else begin
        temp_cnt <= temp_cnt + 28'h0000001;
      end
    end
  end

  // Read mux; unmapped offsets read zero
  always @* begin
    case (ptr)
      `REG_SYSTEM_STATUS: rd_data = system_status;
      `REG_DRIVE_CTRL: rd_data = {load_present, 3'h0, temp_sel, 1'b0,
                                  charge_drive_control,
                                  discharge_drive_control};
      `REG_VOLT_HI: rd_data = {2'h0, volt_result[13:8]};
      `REG_VOLT_LO: rd_data = volt_result[7:0];
      `REG_TEMP_HI: rd_data = {2'h0, temp_result[13:8]};
      `REG_TEMP_LO: rd_data = temp_result[7:0];
      default: rd_data = 8'h00;
    endcase
  end

  // Data line is open drain; only the enable ever moves
  always @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      O_SDA_OUT <= 1'b0;
    end else begin
      O_SDA_OUT <= 1'b0;
    end
  end

endmodule

// ==== rtl/afe_status_map.vh ====
/*
 Register offsets, field positions, reset values and timing counts for
 the status, alert and drive control block. Definitions only; included
 by the target port and the control block.
*/
`ifndef AFE_STATUS_MAP_VH
`define AFE_STATUS_MAP_VH

// Clock and derived rates
`define CLK_HZ 100000000
`define ALERT_SAMPLE_HZ 256000
`define ALERT_DIV (`CLK_HZ / `ALERT_SAMPLE_HZ)
// Last divider count, 390 clocks per sample less one
`define ALERT_DIV_LAST 9'h185
`define ALERT_DELAY_TICKS 3
`define TEMP_UPDATE_S 2
`define TEMP_UPDATE_CYCLES (`TEMP_UPDATE_S * `CLK_HZ)

// Serial target address, 7 bit
`define TARGET_ADDR 7'h08

// Register offsets
`define REG_SYSTEM_STATUS 8'h00
`define REG_DRIVE_CTRL 8'h01
`define REG_VOLT_HI 8'h02
`define REG_VOLT_LO 8'h03
`define REG_TEMP_HI 8'h04
`define REG_TEMP_LO 8'h05

// system_status fields
`define ST_OCD 0
`define ST_SCD 1
`define ST_OV 2
`define ST_UV 3
`define ST_EXT_ALERT 4
`define ST_READY_FAULT 5
`define STATUS_USED_MASK 8'h3F
`define STATUS_FAULT_MASK 8'h2F
`define STATUS_RESET 8'h00

// Drive control fields
`define CTL_DISCHARGE 0
`define CTL_CHARGE 1
`define CTL_TEMP_SEL 3
`define CTL_LOAD_PRESENT 7
`define CTL_WR_MASK 8'h0B
`define CTL_RESET 8'h00

// Conversion code ceiling
`define ADC_MAX_CODE 14'h3DE1

`endif

// ==== verification/afe_host_model.sv ====
/*
 Host model: open-drain master of the two-wire register port.
 Assumes the data line is resolved outside with a pull-up.
*/
`timescale 1ns/1ps
module afe_host_model (
  // Clock
  input wire i_clk,
  // Bus pins
  input wire i_sda,
  output reg o_scl,
  output reg o_sda_oe
);
  // Idle bus: clock high, data released
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  // Half a bit, well above the four-clock minimum
  task half;
    repeat (8) @(posedge i_clk);
  endtask
  // Data moves one clock after the clock fall, never with it
  task bitx(input v, output s);
    begin
      @(posedge i_clk);
      o_sda_oe <= !v;
      half;
      o_scl <= 1'b1;
      half;
      s = i_sda;
      o_scl <= 1'b0;
    end
  endtask
  task xbyte(input [7:0] tx, input mk, output [7:0] rx, output ak);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bitx(tx[i], rx[i]);
      bitx(mk, ak);
    end
  endtask
  // Start, also repeated start from clock low
  task start;
    begin
      @(posedge i_clk);
      o_sda_oe <= 1'b0;
      half;
      o_scl <= 1'b1;
      half;
      o_sda_oe <= 1'b1;
      half;
      o_scl <= 1'b0;
    end
  endtask
  task stop;
    begin
      @(posedge i_clk);
      o_sda_oe <= 1'b1;
      half;
      o_scl <= 1'b1;
      half;
      o_sda_oe <= 1'b0;
      half;
    end
  endtask
  // Write pointer then data; ok when all three bytes acked
  task wr(input [6:0] dev, input [7:0] a, input [7:0] d, output ok);
    reg [7:0] r;
    reg k0, k1, k2;
    begin
      start;
      xbyte({dev, 1'b0}, 1'b1, r, k0);
      xbyte(a, 1'b1, r, k1);
      xbyte(d, 1'b1, r, k2);
      stop;
      ok = !(k0 | k1 | k2);
    end
  endtask
  // Two-byte sequential read, so a pair is taken whole
  task rd(input [6:0] dev, input [7:0] a, output [15:0] d, output ok);
    reg [7:0] r;
    reg k0, k1, k2, k3;
    begin
      start;
      xbyte({dev, 1'b0}, 1'b1, r, k0);
      xbyte(a, 1'b1, r, k1);
      start;
      xbyte({dev, 1'b1}, 1'b1, r, k2);
      xbyte(8'hFF, 1'b0, d[15:8], k3);
      xbyte(8'hFF, 1'b1, d[7:0], k3);
      stop;
      ok = !(k0 | k1 | k2);
    end
  endtask
endmodule

// ==== verification/afe_status_fet_control_asserts.sv ====
/*
 Checker on the ports of the status and drive block.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module afe_status_fet_control_asserts (
  // Clock and reset
  input wire I_SYS_CLK,
  input wire I_RST_B,
  // Inputs
  input wire I_SCL,
  input wire I_ALERT,
  input wire [3:0] I_FAULT_CMP,
  input wire I_GROUP_SUPPLY_LOW,
  // Outputs
  input wire O_SDA_OUT,
  input wire O_SDA_OE,
  input wire O_ALERT_OUT,
  input wire O_ALERT_OE,
  input wire O_CHARGE_DRIVE_PIN,
  input wire O_DISCHARGE_DRIVE_PIN
);
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RST_B);
  wire src;
  wire drv_off;
  reg cause;
  reg [11:0] wait_cnt;
  // Alert causes and drive state
  assign src = I_ALERT | (|I_FAULT_CMP) | I_GROUP_SUPPLY_LOW;
  assign drv_off = !O_CHARGE_DRIVE_PIN && !O_DISCHARGE_DRIVE_PIN;
  // Cycles a cause waits for the pin; the tick grid makes it vary
  always @(posedge I_SYS_CLK) begin
    if (!I_RST_B || O_ALERT_OE) begin
      cause <= 1'b0;
      wait_cnt <= 12'h000;
    end else if (cause || src) begin
      cause <= 1'b1;
      wait_cnt <= wait_cnt + 12'h001;
    end
  end
  a_drive_fault_off: assert property (|I_FAULT_CMP |-> ##6 drv_off)
    else $error("drive pin on during fault");
  a_ready_fault_off: assert property (
    I_GROUP_SUPPLY_LOW |-> ##6 drv_off)
    else $error("drive pin on during ready fault");
  a_reset_quiet: assert property (
    $rose(I_RST_B) |-> drv_off && !O_SDA_OE && !O_ALERT_OE)
    else $error("output active out of reset");
  a_alert_out_high: assert property (
    I_RST_B && $past(I_RST_B) |-> O_ALERT_OUT)
    else $error("alert level not high");
  a_alert_late: assert property (wait_cnt < 12'h6A4)
    else $error("alert pin drive missing");
  // A re-rise after a full clear comes from the held pin, not a new cause
  a_alert_early: assert property (
    $rose(O_ALERT_OE) && cause |-> wait_cnt > 12'h2BC)
    else $error("alert pin driven too early");
  a_sda_out_low: assert property (O_SDA_OUT == 1'b0)
    else $error("data output level not low");
  a_sda_change_low: assert property (
    O_SDA_OE != $past(O_SDA_OE) |-> !I_SCL && !$past(I_SCL, 2))
    else $error("data line moved with clock high");
endmodule
bind afe_status_fet_control afe_status_fet_control_asserts u_chk (
  .I_SYS_CLK(I_SYS_CLK),
  .I_RST_B(I_RST_B),
  .I_SCL(I_SCL),
  .I_ALERT(I_ALERT),
  .I_FAULT_CMP(I_FAULT_CMP),
  .I_GROUP_SUPPLY_LOW(I_GROUP_SUPPLY_LOW),
  .O_SDA_OUT(O_SDA_OUT),
  .O_SDA_OE(O_SDA_OE),
  .O_ALERT_OUT(O_ALERT_OUT),
  .O_ALERT_OE(O_ALERT_OE),
  .O_CHARGE_DRIVE_PIN(O_CHARGE_DRIVE_PIN),
  .O_DISCHARGE_DRIVE_PIN(O_DISCHARGE_DRIVE_PIN)
);

// ==== verification/afe_status_fet_control_tb_top.sv ====
/*
 Testbench: alert, faults, load, codes and registers via the host model.
 Assumes a short temperature update period set here.
*/
`timescale 1ns/1ps
module afe_status_fet_control_tb_top;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg [3:0] fault_cmp = 4'h0;
  reg sup_low = 1'b0;
  reg load_cmp = 1'b0;
  reg ext_alert = 1'b0;
  reg [13:0] volt = 14'h0000;
  reg [13:0] tint = 14'h0000;
  reg [13:0] text = 14'h0000;
  wire scl, host_oe, sda_oe, alert_out, alert_oe, charge_drive_pin, discharge_drive_pin;
  // Open-drain data with pull-up; alert pin has a pull-down
  wire sda = !(host_oe | sda_oe);
  wire alert = (alert_oe & alert_out) | ext_alert;
  wire [15:0] pins = {14'h0000, charge_drive_pin, discharge_drive_pin};
  integer fail_count = 0;
  integer comparisons = 0;
  integer seed = 10487;
  integer i;
  reg [31:0] rnd;
  reg [15:0] d;
  reg [13:0] code;
  reg [7:0] m;
  reg ok;
  always #5 clk = ~clk;
  afe_host_model HOST (.i_clk(clk), .i_sda(sda), .o_scl(scl),
    .o_sda_oe(host_oe));
  afe_status_fet_control #(.TEMP_UPDATE_CYCLES(28'h0000032)) DUT (
    .I_SYS_CLK(clk), .I_RST_B(rst_b), .I_SCL(scl), .I_SDA(sda),
    .O_SDA_OUT(), .O_SDA_OE(sda_oe), .I_ALERT(alert),
    .O_ALERT_OUT(alert_out), .O_ALERT_OE(alert_oe),
    .I_FAULT_CMP(fault_cmp), .I_GROUP_SUPPLY_LOW(sup_low),
    .I_LOAD_CMP(load_cmp), .I_VOLT_CODE(volt), .I_TEMP_INT_CODE(tint),
    .I_TEMP_EXT_CODE(text), .O_CHARGE_DRIVE_PIN(charge_drive_pin),
    .O_DISCHARGE_DRIVE_PIN(discharge_drive_pin));
  task end_of_test;
    begin
      if (fail_count == 0 && comparisons > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("Error %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task w(input [7:0] a, input [7:0] v);
    begin
      HOST.wr(7'h08, a, v, ok);
      chk("write ack", 16'h0001, {15'h0000, ok});
    end
  endtask
  task r(input [7:0] a);
    begin
      HOST.rd(7'h08, a, d, ok);
      chk("read ack", 16'h0001, {15'h0000, ok});
    end
  endtask
  // Source k: fault comparators, 4 group supply, 5 everything
  task src(input integer k, input v);
    begin
      if (k < 4)
        fault_cmp[k] <= v;
      else if (k == 4)
        sup_low <= v;
      else begin
        fault_cmp <= {4{v}};
        sup_low <= v;
      end
    end
  endtask
  // Expected result: ceiling applied, never all ones
  function [15:0] clamp(input [13:0] c);
    clamp = (c > 14'h3DE1) ? 16'h3DE1 : {2'b00, c};
  endfunction
  // Watchdog well beyond the expected run
  initial begin
    #1000000;
    fail_count = fail_count + 1;
    end_of_test;
  end
  initial begin
    cyc(4);
    rst_b <= 1'b1;
    cyc(4);
    // Pulse just over one sample period; pin stays driven afterwards
    ext_alert <= 1'b1;
    cyc(400);
    ext_alert <= 1'b0;
    cyc(1700);
    chk("alert drive", 16'h0001, {15'h0000, alert_oe});
    r(8'h00);
    chk("alert flag", 16'h0010, {8'h00, d[15:8] & 8'h10});
    HOST.wr(7'h09, 8'h01, 8'h03, ok);
    chk("foreign address", 16'h0000, {15'h0000, ok});
    cyc(4);
    chk("drive idle", 16'h0000, pins);
    w(8'h01, 8'h03);
    cyc(4);
    chk("drive on", 16'h0003, pins);
    // Alert flag re-sets from own drive, so it is masked below
    for (i = 0; i < 6; i = i + 1) begin
      m = (i < 4) ? (8'h01 << i) : ((i == 4) ? 8'h20 : 8'h2F);
      src(i, 1'b1);
      cyc(20);
      chk("fault drive", 16'h0000, pins);
      w(8'h00, 8'hFF);
      src(i, 1'b0);
      cyc(10);
      w(8'h00, 8'h00);
      w(8'h00, ~m);
      r(8'h00);
      chk("flag held", {8'h00, m}, {8'h00, d[15:8] & 8'h2F});
      chk("ctrl off", 16'h0000, {14'h0000, d[1:0]});
      w(8'h00, (i == 5) ? 8'hFF : m);
      r(8'h00);
      chk("flag clear", 16'h0000, {8'h00, d[15:8] & 8'h2F});
      chk("no restart", 16'h0000, pins);
      w(8'h01, 8'h03);
      cyc(4);
      chk("drive back", 16'h0003, pins);
    end
    w(8'h01, 8'h00);
    load_cmp <= 1'b1;
    cyc(4);
    r(8'h01);
    chk("load seen", 16'h0080, {8'h00, d[15:8] & 8'h80});
    w(8'h01, 8'h01);
    r(8'h01);
    chk("load gated", 16'h0000, {8'h00, d[15:8] & 8'h80});
    w(8'h01, 8'h00);
    load_cmp <= 1'b0;
    cyc(4);
    r(8'h01);
    chk("load gone", 16'h0000, {8'h00, d[15:8] & 8'h80});
    // Ceiling corners, then random codes
    for (i = 0; i < 6; i = i + 1) begin
      rnd = $random(seed);
      code = (i == 0) ? 14'h3DE1 : (i == 1) ? 14'h3DE2 : rnd[13:0];
      code = (i == 2) ? 14'h3FFF : code;
      volt <= code;
      cyc(2);
      r(8'h02);
      chk("voltage", clamp(code), d);
    end
    rnd = $random(seed);
    tint <= {1'b0, rnd[12:0]};
    text <= {1'b0, rnd[28:16]};
    cyc(104);
    r(8'h04);
    chk("temp internal", {3'b000, rnd[12:0]}, d);
    w(8'h01, 8'h08);
    cyc(104);
    r(8'h04);
    chk("temp external", {3'b000, rnd[28:16]}, d);
    end_of_test;
  end
endmodule
